// [shared/slvm_pkg.sv]
// constants, field layouts and carrier types for the supply monitor
// assumes one core clock domain and an apb slave with 32-bit data
package slvm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00; // configuration bits
  localparam logic [7:0] ADDR_STATUS = 8'h04; // monitor status, ro
  localparam logic [7:0] ADDR_EVENT = 8'h08; // sticky events, ro
  localparam logic [7:0] ADDR_EVCLR = 8'h0c; // event clear, wo
  localparam logic [7:0] ADDR_EVEN = 8'h10; // event enable, rw

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_W = 4; // configuration width
  localparam int ST_FLAG = 0; // low_supply_flag in status
  localparam int ST_RESET = 1; // reset request in status
  localparam int ST_ACTIVE = 2; // monitor active in status
  localparam int EV_W = 3; // event register width
  localparam int EV_FELL = 0; // flag went to one
  localparam int EV_ROSE = 1; // flag went to zero
  localparam int EV_RESET = 2; // monitor reset began

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0; // 3-V, power and resets enabled, stop mode off
  localparam logic [EV_W-1:0] EV_RESET_VAL = 3'h0; // no events
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000; // idle read

  // ----------------------------------------------------------------
  // comparator bundle order in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int CMP_W = 4; // four comparator indications

  // configuration bits, msb first
  typedef struct packed {
    logic trip_level_select; // 1 = 5-V, 0 = 3-V
    logic monitor_stop_mode_enable; // run in stop mode
    logic monitor_reset_disable; // 1 = no monitor resets
    logic monitor_power_disable; // 1 = monitor off
  } slvm_cfg_s;

  // comparator indications, one per level and direction
  typedef struct packed {
    logic above_rise_5v; // supply above 5-V rising level
    logic above_rise_3v; // supply above 3-V rising level
    logic below_fall_5v; // supply below 5-V falling level
    logic below_fall_3v; // supply below 3-V falling level
  } slvm_cmp_s;

endpackage

// [rtl/slvm_sync.sv]
// two-stage synchroniser for a vector of asynchronous levels
// assumes every bit is an independent slowly changing level
`timescale 1ns/1ps

module slvm_sync #(
  parameter int W = 4
) (
  // clock, reset and enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // -----------------------------------------------------------------
  // one pair of flops per bit
  // -----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic stage1; // read only by the second stage
      // first stage catches the pin, second resolves metastability
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          stage1 <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else if (clk_en)
        begin
          stage1 <= async_in[i];
          sync_out[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule

// [rtl/slvm_top.sv]
// supply monitor control: hysteretic flag, reset request, apb regs
// assumes comparators are asynchronous levels; mode inputs are
// from logic on core_clk; resetn is the system reset
`timescale 1ns/1ps

module slvm_top (
  // clock, reset and enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator indications, asynchronous
  input wire slvm_pkg::slvm_cmp_s cmp_async,
  // low-power mode indications from the core
  input wire logic mcu_wait,
  input wire logic mcu_stop,
  // outputs to analog, reset controller and interrupt logic
  output logic comparator_power_on,
  output logic trip_level_select,
  output logic reset_request,
  output logic irq
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  slvm_pkg::slvm_cmp_s cmp; // synchronised comparator levels
  slvm_pkg::slvm_cfg_s cfg; // configuration register
  logic [slvm_pkg::EV_W-1:0] evt; // sticky event bits
  logic [slvm_pkg::EV_W-1:0] evt_en; // event enables
  logic [slvm_pkg::EV_W-1:0] next_evt_set; // events this cycle
  logic low_supply_flag; // hysteretic status flag
  logic tls_prev; // trip select of last cycle
  logic active; // monitor is running
  logic reset_en; // monitor may reset the device
  logic below_fall; // supply below selected falling level
  logic above_rise; // supply above selected rising level
  logic level_raised; // trip select just went to 5-V
  logic trip; // reset request must start now
  logic acc; // apb access phase, first cycle
  logic wr; // write taken this cycle

  // -----------------------------------------------------------------
  // comparator synchroniser
  // -----------------------------------------------------------------
  // every comparator level is resynchronised before use
  slvm_sync #(
    .W(slvm_pkg::CMP_W)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(cmp_async),
    .sync_out(cmp)
  );

  // -----------------------------------------------------------------
  // mode and level selection
  // -----------------------------------------------------------------
  // stop mode needs the stop enable; wait and run need power only
  assign active = !cfg.monitor_power_disable
    && (!mcu_stop || cfg.monitor_stop_mode_enable);
  // polling mode is power on with resets off, set by software
  assign reset_en = active && !cfg.monitor_reset_disable;
  // pick the comparator pair for the selected level
  assign below_fall = cfg.trip_level_select ? cmp.below_fall_5v
    : cmp.below_fall_3v;
  assign above_rise = cfg.trip_level_select ? cmp.above_rise_5v
    : cmp.above_rise_3v;
  assign level_raised = cfg.trip_level_select && !tls_prev;
  // a fall, or raising the level while not above its rising point
  assign trip = reset_en
    && (below_fall || (level_raised && !above_rise));

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  assign acc = psel && penable && !pready;
  // a write lands at the edge where the master sees pready high
  assign wr = psel && penable && pready && pwrite;

  // -----------------------------------------------------------------
  // configuration register
  // -----------------------------------------------------------------
  // power-on value selects the 3-V level and enables the monitor
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg <= slvm_pkg::CFG_RESET;
      tls_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      tls_prev <= cfg.trip_level_select;
      if (wr && paddr == slvm_pkg::ADDR_CONFIG)
      begin
        cfg <= pwdata[slvm_pkg::CFG_W-1:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // hysteretic low-supply flag
  // -----------------------------------------------------------------
  // set below falling, clear above rising, hold between; system
  // reset clears it; frozen while the monitor is off
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_supply_flag <= 1'b0;
    end
    else if (clk_en && active)
    begin
      if (below_fall)
      begin
        low_supply_flag <= 1'b1;
      end
      else if (above_rise)
      begin
        low_supply_flag <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // reset request
  // -----------------------------------------------------------------
  // once begun it is held until the supply is above the rising level
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_request <= 1'b0;
    end
    else if (clk_en)
    begin
      if (trip)
      begin
        reset_request <= 1'b1;
      end
      else if (reset_request && above_rise)
      begin
        reset_request <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // analog control outputs
  // -----------------------------------------------------------------
  // registered copies so every output leaves a flop
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      comparator_power_on <= 1'b0;
      trip_level_select <= 1'b0;
    end
    else if (clk_en)
    begin
      comparator_power_on <= active;
      trip_level_select <= cfg.trip_level_select;
    end
  end

  // -----------------------------------------------------------------
  // sticky events and interrupt line
  // -----------------------------------------------------------------
  // events: flag rises, flag falls, monitor reset begins
  always_comb
  begin
    next_evt_set = slvm_pkg::EV_RESET_VAL;
    next_evt_set[slvm_pkg::EV_FELL] = active && below_fall
      && !low_supply_flag;
    next_evt_set[slvm_pkg::EV_ROSE] = active && !below_fall
      && above_rise && low_supply_flag;
    next_evt_set[slvm_pkg::EV_RESET] = trip && !reset_request;
  end

  // a set in the same cycle as its clear wins
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      evt <= slvm_pkg::EV_RESET_VAL;
      evt_en <= slvm_pkg::EV_RESET_VAL;
    end
    else if (clk_en)
    begin
      if (wr && paddr == slvm_pkg::ADDR_EVCLR)
      begin
        evt <= (evt & ~pwdata[slvm_pkg::EV_W-1:0]) | next_evt_set;
      end
      else
      begin
        evt <= evt | next_evt_set;
      end
      if (wr && paddr == slvm_pkg::ADDR_EVEN)
      begin
        evt_en <= pwdata[slvm_pkg::EV_W-1:0];
      end
    end
  end

  // the monitor core never interrupts; only software-enabled
  // status events reach this line, all disabled after reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      irq <= |(evt & evt_en);
    end
  end

  // -----------------------------------------------------------------
  // apb answer: one wait state, registered data and error
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= slvm_pkg::RDATA_RESET;
    end
    else if (clk_en)
    begin
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= slvm_pkg::RDATA_RESET;
      if (acc)
      begin
        case (paddr)
          slvm_pkg::ADDR_CONFIG:
          begin
            prdata[slvm_pkg::CFG_W-1:0] <= cfg;
          end
          slvm_pkg::ADDR_STATUS:
          begin
            // reading the flag lets software poll the supply
            prdata[slvm_pkg::ST_FLAG] <= low_supply_flag;
            prdata[slvm_pkg::ST_RESET] <= reset_request;
            prdata[slvm_pkg::ST_ACTIVE] <= active;
          end
          slvm_pkg::ADDR_EVENT:
          begin
            prdata[slvm_pkg::EV_W-1:0] <= evt;
          end
          slvm_pkg::ADDR_EVCLR:
          begin
            // write-only, reads as zero
            prdata <= slvm_pkg::RDATA_RESET;
          end
          slvm_pkg::ADDR_EVEN:
          begin
            prdata[slvm_pkg::EV_W-1:0] <= evt_en;
          end
          default:
          begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // assertions and covers
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_flag_sets: assert property (clk_en && active && below_fall
    |=> low_supply_flag) else $error("flag not set below falling");
  a_flag_clears: assert property (clk_en && active && !below_fall
    && above_rise |=> !low_supply_flag)
    else $error("flag not cleared above rising");
  a_flag_holds: assert property (!below_fall && !above_rise
    |=> $stable(low_supply_flag)) else $error("flag moved in band");
  a_wait_active: assert property (clk_en && mcu_wait
    && !mcu_stop && !cfg.monitor_power_disable |=> comparator_power_on)
    else $error("monitor idle in wait mode");
  a_stop_frozen: assert property (mcu_stop
    && !cfg.monitor_stop_mode_enable
    |=> $stable(low_supply_flag) && !comparator_power_on)
    else $error("monitor ran in stop without enable");
  a_reset_trips: assert property (clk_en
    && !cfg.monitor_reset_disable
    && !cfg.monitor_power_disable && !mcu_stop && below_fall
    |=> reset_request) else $error("no reset below falling");
  a_reset_held: assert property (reset_request && !above_rise
    |=> reset_request) else $error("reset dropped early");
  a_raise_resets: assert property (clk_en && reset_en
    && level_raised && !above_rise ##1 clk_en
    |-> reset_request ##1 reset_request || above_rise)
    else $error("raising level did not reset");
  a_default_3v: assert property (!cfg.trip_level_select
    && !(wr && paddr == slvm_pkg::ADDR_CONFIG)
    |=> !cfg.trip_level_select) else $error("level left 3-V alone");
  a_irq_masked: assert property (evt_en == slvm_pkg::EV_RESET_VAL
    && $stable(evt_en) |=> !irq) else $error("irq without enable");
  a_apb_ready: assert property (clk_en && acc |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  c_flag_set: cover property (!low_supply_flag ##1 low_supply_flag);
  c_reset_run: cover property ($rose(reset_request)
    ##[1:50] $fell(reset_request));
  c_raise_reset: cover property (level_raised && trip);
  c_irq: cover property ($rose(irq));
  c_wait_reset: cover property (mcu_wait && trip);

endmodule

// [test/tb_supply_low_voltage_monitor.sv]
// self-checking bench for the supply monitor control block
// assumes slvm_top with an apb slave and a 40 MHz core_clk
`timescale 1ns/1ps

module tb_supply_low_voltage_monitor;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0; // 40 MHz core clock
  logic resetn = 1'b0; // system reset, active low
  logic clk_en = 1'b1; // always running here
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  slvm_pkg::slvm_cmp_s cmp_async = 4'hc; // supply high at start
  logic mcu_wait = 1'b0;
  logic mcu_stop = 1'b0;
  logic comparator_power_on;
  logic trip_level_select;
  logic reset_request;
  logic irq;
  logic [31:0] rd; // last read data
  logic err; // last slave error
  logic f; // expected low-supply flag
  logic [3:0] v; // random comparator pattern
  int n_mismatch = 0;
  int checks_done = 0;

  // clock: toggle every half period
  always #12.5 core_clk = ~core_clk;

  slvm_top slvm_top_i (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_async(cmp_async), .mcu_wait(mcu_wait),
    .mcu_stop(mcu_stop), .comparator_power_on(comparator_power_on),
    .trip_level_select(trip_level_select),
    .reset_request(reset_request), .irq(irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wait a number of rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // wait until pready is seen high, then check for exactly one wait cycle
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("wait states", 32'(n), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // read a register and compare data and error
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
    chk("pslverr", 32'(err), 32'h0);
  endtask

  // drive comparators and let them pass sync and flag stages
  task automatic set_cmp(input logic [3:0] c);
    cmp_async <= slvm_pkg::slvm_cmp_s'(c);
    tick(4);
  endtask

  // expected flag: below wins, above clears, otherwise holds
  function automatic logic hyst(input logic p, input logic b,
                                input logic a);
    if (b)
      return 1'b1;
    if (a)
      return 1'b0;
    return p;
  endfunction

  // expected status word
  function automatic logic [31:0] stat(input logic fl, input logic r,
                                       input logic act);
    return {29'h0, act, r, fl};
  endfunction

  task automatic done_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: far beyond the expected run length
  // ----------------------------------------------------------------
  initial
  begin
    #1000000;
    n_mismatch++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(70));
    tick(6);
    resetn <= 1'b1;
    tick(1);
    // reset values, unmapped access
    rchk("config", slvm_pkg::ADDR_CONFIG, 32'h0);
    rchk("status", slvm_pkg::ADDR_STATUS, stat(0, 0, 1));
    chk("trip", 32'(trip_level_select), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    done_test("reset");
    // forced reset with hysteresis
    set_cmp(4'h1);
    chk("rst fall", 32'(reset_request), 32'h1);
    rchk("status low", slvm_pkg::ADDR_STATUS, stat(1, 1, 1));
    set_cmp(4'h0);
    chk("rst between", 32'(reset_request), 32'h1);
    set_cmp(4'h4);
    chk("rst rise", 32'(reset_request), 32'h0);
    rchk("status ok", slvm_pkg::ADDR_STATUS, stat(0, 0, 1));
    rchk("events", slvm_pkg::ADDR_EVENT, 32'h7);
    chk("irq none", 32'(irq), 32'h0);
    apb(1'b1, slvm_pkg::ADDR_EVCLR, 32'h7);
    rchk("ev clear", slvm_pkg::ADDR_EVENT, 32'h0);
    done_test("forced");
    // polled mode with event interrupt
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h2);
    apb(1'b1, slvm_pkg::ADDR_EVEN, 32'h1);
    set_cmp(4'h1);
    chk("rst polled", 32'(reset_request), 32'h0);
    rchk("status pol", slvm_pkg::ADDR_STATUS, stat(1, 0, 1));
    chk("irq on", 32'(irq), 32'h1);
    apb(1'b1, slvm_pkg::ADDR_EVEN, 32'h0);
    tick(1);
    chk("irq mask", 32'(irq), 32'h0);
    apb(1'b1, slvm_pkg::ADDR_EVEN, 32'h1);
    tick(1);
    chk("irq unmask", 32'(irq), 32'h1);
    rchk("even", slvm_pkg::ADDR_EVEN, 32'h1);
    apb(1'b1, slvm_pkg::ADDR_EVCLR, 32'h1);
    tick(1);
    chk("irq clr", 32'(irq), 32'h0);
    set_cmp(4'h4);
    chk("irq rose", 32'(irq), 32'h0);
    done_test("polled");
    // random comparator walk, resets disabled
    f = 1'b0;
    repeat (24)
    begin
      v = 4'($urandom) & 4'h5;
      set_cmp(v);
      f = hyst(f, v[0], v[2]);
      rchk("rand flag", slvm_pkg::ADDR_STATUS, stat(f, 0, 1));
    end
    set_cmp(4'h4);
    done_test("random");
    // trip level select
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h0);
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h8);
    tick(2);
    chk("trip out", 32'(trip_level_select), 32'h1);
    chk("rst select", 32'(reset_request), 32'h1);
    set_cmp(4'hc);
    chk("rst 5v up", 32'(reset_request), 32'h0);
    set_cmp(4'hd);
    chk("rst 3v ign", 32'(reset_request), 32'h0);
    set_cmp(4'he);
    chk("rst 5v low", 32'(reset_request), 32'h1);
    set_cmp(4'hc);
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h0);
    done_test("trip");
    // wait and stop modes
    mcu_wait <= 1'b1;
    tick(2);
    chk("pwr wait", 32'(comparator_power_on), 32'h1);
    set_cmp(4'h1);
    chk("rst wait", 32'(reset_request), 32'h1);
    set_cmp(4'hc);
    mcu_wait <= 1'b0;
    mcu_stop <= 1'b1;
    tick(2);
    chk("pwr stop", 32'(comparator_power_on), 32'h0);
    set_cmp(4'h1);
    chk("rst stop", 32'(reset_request), 32'h0);
    set_cmp(4'hc);
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h4);
    tick(1);
    chk("pwr stopen", 32'(comparator_power_on), 32'h1);
    set_cmp(4'h1);
    chk("rst stopen", 32'(reset_request), 32'h1);
    set_cmp(4'hc);
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h5);
    tick(1);
    chk("pwr off", 32'(comparator_power_on), 32'h0);
    mcu_stop <= 1'b0;
    tick(2);
    chk("pwr off run", 32'(comparator_power_on), 32'h0);
    done_test("lowpower");
    // system reset clears a held flag
    apb(1'b1, slvm_pkg::ADDR_CONFIG, 32'h2);
    set_cmp(4'h1);
    set_cmp(4'h0);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    rchk("status rst", slvm_pkg::ADDR_STATUS, stat(0, 0, 1));
    rchk("config rst", slvm_pkg::ADDR_CONFIG, 32'h0);
    done_test("sysreset");
    tally_and_finish;
  end
endmodule
